// ---- pit_trigger.v ----
// Pulse width and interval trigger qualifier with register port.
//
// Overview of operation
// RULE1 - Glitch mode compares width at-most or at-least.
// RULE2 - Max-width mode triggers when width within limit.
// RULE3 - Width timer restarts on opposite edge.
// RULE4 - Limits cover 600 ps up to 20 s; code spans one 4 ns cycle to 2^32-1 cycles (about 17.2 s).
// RULE5 - Outside range triggers at or beyond limits.
// RULE6 - Inside range triggers between both limits.
// RULE7 - Range limits and restart match glitch mode.
// RULE8 - Interval measures between like selected edges.
// RULE9 - Interval timer restarts on each selected edge.
// RULE10 - Interval-smaller triggers within maximum interval.
// RULE11 - Interval-larger triggers after minimum interval.
// RULE12 - Interval-in-range triggers between both limits.
// RULE13 - Interval-outside triggers below lower or above upper.
// RULE14 - Interval limits cover 2 ns up to 20 s; code spans one 4 ns cycle to 2^32-1 cycles (about 17.2 s).
// RULE15 - Slope chooses edge, stored per source.
// RULE16 - Inclusive cycle counts, overflow exceeds limits.
// RULE17 - One-cycle trigger, none before first measurement.
`timescale 1ns/1ps
`include "pit_map.vh"
module pit_trigger (
   // Clock and reset.
   input  wire                   clk_i,
   input  wire                   rst_b_i,
   // Digitised trigger source states after the comparators.
   input  wire [`PIT_SRC_N-1:0]  src_i,
   // Register port.
   input  wire [`PIT_ADDR_W-1:0] reg_addr_i,
   input  wire [31:0]            reg_wdata_i,
   input  wire                   reg_wr_i,
   input  wire                   reg_rd_i,
   output reg  [31:0]            reg_rdata_o,
   // Trigger and interrupt.
   output reg                    trig_o,
   output wire                   irq_o
);

   // Limits are in sample-clock cycles; 20 s at 4 ns needs 33 bits.
   localparam [63:0] MAX_LIMIT_WIDE =
      `PIT_MAX_LIMIT_S * 64'd1000000000000 / `PIT_CLK_PS; // RULE4 RULE14
   localparam [`PIT_CNT_W-1:0] MAX_LIMIT_CYC =
      MAX_LIMIT_WIDE[`PIT_CNT_W-1:0]; // RULE4 RULE14

   reg  [31:0]              ctrl_q;
   reg  [`PIT_CNT_W-1:0]    lim_lo_q;
   reg  [`PIT_CNT_W-1:0]    lim_hi_q;
   reg  [`PIT_SRC_N-1:0]    slope_q;
   reg  [`PIT_ST_W-1:0]     status_q;
   reg  [`PIT_ST_W-1:0]     irq_en_q;
   reg  [`PIT_CNT_W-1:0]    meas_q;
   reg                      src_q;
   reg                      en_q;
   reg  [1:0]               sel_q;
   reg                      armed_q;
   reg  [`PIT_ST_W-1:0]     clr_bits;
   reg  [`PIT_CNT_W-1:0]    wr_lim;

   wire                     en      = ctrl_q[`PIT_CTRL_EN_BIT];
   wire [2:0]               mode    =
      ctrl_q[`PIT_CTRL_MODE_MSB:`PIT_CTRL_MODE_LSB];
   wire [1:0]               src_sel =
      ctrl_q[`PIT_CTRL_SRC_MSB:`PIT_CTRL_SRC_LSB];

   // Selected source and its own stored slope, high meaning rising.
   wire                     src_now = src_i[src_sel];
   wire                     rising  = slope_q[src_sel]; // RULE15
   // Edges count only once the history holds the same enabled source;
   // otherwise a source switch would look like a transition.
   wire                     live    = en & en_q & (src_sel == sel_q);
   wire                     sel_edge =
      live & (src_now != src_q) & (src_now == rising); // RULE15
   wire                     opp_edge =
      live & (src_now != src_q) & (src_now != rising);

   // Interval modes have mode MSB set.
   wire                     is_int  = mode[2];

   // Width timer restarts on the opposite edge, interval timer on the
   // selected edge, so each timer spans exactly the measured stretch.
   wire                     tmr_clr = is_int ? sel_edge : opp_edge; // RULE3 RULE7 RULE9
   wire [`PIT_CNT_W-1:0]    cnt;
   wire                     ovf;

   pit_edge_timer u_timer (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .clr_i   (tmr_clr),
      .count_o (cnt),
      .ovf_o   (ovf)
   );

   // Comparisons are inclusive except lt_lo and gt_hi; overflow counts as beyond every limit.
   wire le_lo = ~ovf & (cnt <= lim_lo_q); // RULE16
   wire ge_lo = ovf | (cnt >= lim_lo_q);  // RULE16
   wire le_hi = ~ovf & (cnt <= lim_hi_q);
   wire ge_hi = ovf | (cnt >= lim_hi_q);
   wire lt_lo = ~ovf & (cnt < lim_lo_q);
   wire gt_hi = ovf | (cnt > lim_hi_q);

   reg qualify;

   // Qualification of the measurement that ends on this selected edge.
   always @* begin
      case (mode)
         `PIT_MODE_W_MAX:   qualify = le_lo;           // RULE1 RULE2
         `PIT_MODE_W_MIN:   qualify = ge_lo;           // RULE1
         `PIT_MODE_W_OUT:   qualify = le_lo | ge_hi;   // RULE5
         `PIT_MODE_W_IN:    qualify = ge_lo & le_hi;   // RULE6
         `PIT_MODE_I_SMALL: qualify = le_lo;           // RULE8 RULE10
         `PIT_MODE_I_LARGE: qualify = ge_lo;           // RULE11
         `PIT_MODE_I_IN:    qualify = ge_lo & le_hi;   // RULE12
         `PIT_MODE_I_OUT:   qualify = lt_lo | gt_hi;   // RULE13
         default:           qualify = 1'b0;
      endcase
   end

   // The width is only whole once the opposite edge has restarted the
   // timer; the interval once a first selected edge has.
   wire fire = sel_edge & armed_q & qualify; // RULE17

   // Edge history, arming and the trigger pulse. Arming drops on disable
   // so a stale count from before re-enable never qualifies.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         src_q   <= 1'b0;
         en_q    <= 1'b0;
         sel_q   <= 2'h0;
         armed_q <= 1'b0;
         trig_o  <= 1'b0;
         meas_q  <= {`PIT_CNT_W{1'b0}};
      end else begin
         src_q  <= src_now;
         en_q   <= en;
         sel_q  <= src_sel;
         trig_o <= fire; // RULE17
         if (!en) begin
            armed_q <= 1'b0;
         end else if (tmr_clr) begin
            armed_q <= 1'b1; // RULE17
         end
         if (sel_edge && armed_q) begin
            meas_q <= ovf ? {`PIT_CNT_W{1'b1}} : cnt;
         end
      end
   end

   // Clear strobe bits and clamped limit value for register writes.
   always @* begin
      clr_bits = {`PIT_ST_W{1'b0}};
      if (reg_wr_i && reg_addr_i == `PIT_REG_IRQ_CLR) begin
         clr_bits = reg_wdata_i[`PIT_ST_W-1:0];
      end
      wr_lim = {1'b0, reg_wdata_i};
      if (wr_lim > MAX_LIMIT_CYC) begin
         wr_lim = MAX_LIMIT_CYC;
      end
      if (wr_lim == {`PIT_CNT_W{1'b0}}) begin
         wr_lim = `PIT_LIM_RST;
      end
   end

   // Control and limit registers; limits span one cycle .. 2^32-1 cycles (about 17.2 s).
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q   <= `PIT_CTRL_RST;
         lim_lo_q <= `PIT_LIM_RST;
         lim_hi_q <= `PIT_LIM_RST;
         slope_q  <= {`PIT_SRC_N{1'b1}};
         irq_en_q <= {`PIT_ST_W{1'b0}};
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `PIT_REG_CTRL:      ctrl_q   <= reg_wdata_i;
            `PIT_REG_LIM_LO:    lim_lo_q <= wr_lim; // RULE4 RULE14
            `PIT_REG_LIM_HI:    lim_hi_q <= wr_lim; // RULE4 RULE14
            `PIT_REG_SRC_SLOPE: slope_q  <= reg_wdata_i[`PIT_SRC_N-1:0];
            `PIT_REG_IRQ_EN:    irq_en_q <= reg_wdata_i[`PIT_ST_W-1:0];
            default:            ctrl_q   <= ctrl_q;
         endcase
      end
   end

   // Sticky status: a new event in the clearing cycle wins over the clear.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_q <= {`PIT_ST_W{1'b0}};
      end else begin
         status_q <= (status_q & ~clr_bits) | {ovf & armed_q, fire};
      end
   end

   assign irq_o = |(status_q & irq_en_q);

   // Read data stands in the cycle after the read strobe only.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `PIT_REG_CTRL:      reg_rdata_o <= ctrl_q;
            `PIT_REG_LIM_LO:    reg_rdata_o <= lim_lo_q[31:0];
            `PIT_REG_LIM_HI:    reg_rdata_o <= lim_hi_q[31:0];
            `PIT_REG_STATUS:    reg_rdata_o <= {30'h0, status_q};
            `PIT_REG_IRQ_EN:    reg_rdata_o <= {30'h0, irq_en_q};
            `PIT_REG_MEAS:      reg_rdata_o <= meas_q[31:0];
            `PIT_REG_SRC_SLOPE: reg_rdata_o <= {28'h0, slope_q};
            default:            reg_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

endmodule

// ---- pit_map.vh ----
// Register map, field layout and timing constants of the pulse interval trigger.
`ifndef PIT_MAP_VH
`define PIT_MAP_VH

// Register addresses, 4 bits, word index.
`define PIT_ADDR_W        4
`define PIT_REG_CTRL      4'h0
`define PIT_REG_LIM_LO    4'h1
`define PIT_REG_LIM_HI    4'h2
`define PIT_REG_STATUS    4'h3
`define PIT_REG_IRQ_EN    4'h4
`define PIT_REG_IRQ_CLR   4'h5
`define PIT_REG_MEAS      4'h6
`define PIT_REG_SRC_SLOPE 4'h7

// Control register fields.
`define PIT_CTRL_EN_BIT    0
`define PIT_CTRL_MODE_LSB  1
`define PIT_CTRL_MODE_MSB  3
`define PIT_CTRL_SRC_LSB   4
`define PIT_CTRL_SRC_MSB   5
`define PIT_CTRL_RST       32'h0000_0000

// Mode encodings.
`define PIT_MODE_W_MAX    3'h0
`define PIT_MODE_W_MIN    3'h1
`define PIT_MODE_W_OUT    3'h2
`define PIT_MODE_W_IN     3'h3
`define PIT_MODE_I_SMALL  3'h4
`define PIT_MODE_I_LARGE  3'h5
`define PIT_MODE_I_IN     3'h6
`define PIT_MODE_I_OUT    3'h7

// Status and interrupt bit positions.
`define PIT_ST_TRIG_BIT   0
`define PIT_ST_OVF_BIT    1
`define PIT_ST_W          2

// Timing: 250 MHz sample clock, limits held as cycle counts.
`define PIT_CLK_PS        4000
`define PIT_MAX_LIMIT_S   20
`define PIT_CNT_W         33
`define PIT_SRC_N         4
`define PIT_LIM_RST       33'h0_0000_0001

`endif

// ---- pit_edge_timer.v ----
// Saturating cycle counter that restarts on a clear pulse.
`timescale 1ns/1ps
`include "pit_map.vh"
module pit_edge_timer (
   // Clock and reset.
   input  wire                   clk_i,
   input  wire                   rst_b_i,
   // Control.
   input  wire                   clr_i,
   // Result.
   output wire [`PIT_CNT_W-1:0]  count_o,
   output wire                   ovf_o
);

   reg  [`PIT_CNT_W-1:0] cnt_q;
   reg                   ovf_q;

   // Counts sample clocks since the last clear; sticks at full scale so a
   // very long pulse still compares as longer than any limit.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= {`PIT_CNT_W{1'b0}};
         ovf_q <= 1'b0;
      end else if (clr_i) begin
         cnt_q <= {{(`PIT_CNT_W-1){1'b0}}, 1'b1};
         ovf_q <= 1'b0;
      end else if (&cnt_q) begin
         ovf_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + {{(`PIT_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign count_o = cnt_q;
   assign ovf_o   = ovf_q;

endmodule

// ---- pit_trigger_asserts.sv ----
// Port assertions and covers for the pulse interval trigger.
`timescale 1ns/1ps
module pit_trigger_chk (
   // Clock, reset and sources.
   input wire        clk_i,
   input wire        rst_b_i,
   input wire [3:0]  src_i,
   // Register port.
   input wire [3:0]  reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [31:0] reg_rdata_o,
   // Trigger and interrupt.
   input wire        trig_o,
   input wire        irq_o
);
   reg       en_q;
   reg [1:0] ien_q;
   // Shadow what software enabled, since the checks cannot see inside.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         en_q  <= 1'b0;
         ien_q <= 2'h0;
      end else if (reg_wr_i && reg_addr_i == 4'h0) begin
         en_q <= reg_wdata_i[0];
      end else if (reg_wr_i && reg_addr_i == 4'h4) begin
         ien_q <= reg_wdata_i[1:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   trig_one_shot_a: assert property (trig_o |=> !trig_o)
      else $error("trigger wider than one cycle");
   trig_on_edge_a: assert property (trig_o |-> $past(src_i) !=
      $past(src_i, 2) || $past(src_i, 2) != $past(src_i, 3) ||
      $past(src_i, 3) != $past(src_i, 4)) else $error("trigger sans edge");
   trig_off_quiet_a: assert property ((!en_q) [*3] |-> !trig_o)
      else $error("trigger while disabled");
   irq_needs_en_a: assert property (irq_o |-> ien_q != 2'h0)
      else $error("interrupt without enable");
   irq_follows_a: assert property (trig_o && ien_q[0] |-> ##[0:1] irq_o)
      else $error("interrupt missing after trigger");
   rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data outside read answer");
   unmapped_zero_a: assert property (reg_rd_i && reg_addr_i > 4'h7 |=>
      reg_rdata_o == 32'h0) else $error("unmapped read not zero");
   status_sticky_a: assert property (reg_rd_i && reg_addr_i == 4'h3 &&
      $past(trig_o) |=> reg_rdata_o[0]) else $error("status lost trigger");
   cover property (trig_o);
   cover property (irq_o);
   cover property (reg_rd_i && reg_addr_i == 4'h6);
endmodule
bind pit_trigger pit_trigger_chk u_chk (.clk_i, .rst_b_i, .src_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .trig_o, .irq_o);

// ---- pit_src_model.sv ----
// Model of the comparator outputs that feed the trigger sources.
`timescale 1ns/1ps
module pit_src_model (
   // Clock.
   input  wire       clk_i,
   // Digitised source states.
   output reg  [3:0] src_o
);
   initial src_o = 4'h0;
   // Levels change just after an edge and hold whole cycles, so each
   // transition is seen by exactly one sampling edge.
   task put(input [3:0] v, input integer n);
      begin
         src_o <= v;
         repeat (n) @(posedge clk_i);
      end
   endtask
endmodule

// ---- tb_pulse_interval_trigger.sv ----
// Self-checking testbench of the pulse interval trigger.
`timescale 1ns/1ps
module tb_pulse_interval_trigger;
   reg         clk_i;
   reg         rst_b_i;
   reg  [3:0]  reg_addr_i;
   reg  [31:0] reg_wdata_i;
   reg         reg_wr_i;
   reg         reg_rd_i;
   reg         rd_seen = 1'b0;
   reg  [3:0]  fl;
   reg         ien;
   wire [3:0]  src;
   wire [31:0] reg_rdata_o;
   wire        trig_o;
   wire        irq_o;
   integer     fails, n_checks, seed, md, j, t, e, t0;
   integer     trig_n = 0;
   reg  [31:0] exq[$];
   pit_src_model u_src (.clk_i(clk_i), .src_o(src));
   pit_trigger DUT (.src_i(src), .clk_i, .rst_b_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .trig_o, .irq_o);
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task chk(input [31:0] s, input [31:0] x, input string nm);
      begin
         n_checks = n_checks + 1;
         if (s !== x) begin
            fails = fails + 1;
            $display("BAD %0s exp %h seen %h", nm, x, s);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d fails %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // A gap cycle follows each strobe so no signal is set twice at once.
   task wr(input [3:0] a, input [31:0] d);
      begin
         reg_addr_i  <= a;
         reg_wdata_i <= d;
         reg_wr_i    <= 1'b1;
         @(posedge clk_i);
         reg_wr_i    <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task rd(input [3:0] a, input [31:0] x);
      begin
         exq.push_back(x);
         reg_addr_i <= a;
         reg_rd_i   <= 1'b1;
         @(posedge clk_i);
         reg_rd_i   <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   // Expected trigger for a measured count with limits 8 and 14.
   function integer hit(input integer m, input integer w);
      case (m)
         0, 4: hit = w <= 8;
         1, 5: hit = w >= 8;
         2: hit = w <= 8 || w >= 14;
         7: hit = w < 8 || w > 14;
         default: hit = w >= 8 && w <= 14;
      endcase
   endfunction
   // Each read answer is matched to the oldest expectation.
   always @(posedge clk_i) begin
      if (rd_seen)
         chk(reg_rdata_o, exq.pop_front(), "rdata");
      rd_seen <= reg_rd_i;
      if (trig_o)
         trig_n <= trig_n + 1;
   end
   // Cut a hang short; the run needs far fewer cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      fails = fails + 1;
      wrap_up;
   end
   initial begin
      seed = 32'hd4e7b8dd;
      fails = 0;
      n_checks = 0;
      rst_b_i = 1'b0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 32'h0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      wr(4'h9, 32'hffff_ffff);
      wr(4'h3, 32'h1);
      for (j = 0; j < 10; j = j + 1)
         if (j != 6) rd(j[3:0], (j == 1 || j == 2) ? 1 : (j == 7) ? 32'hf : 0);
      $display("reset and map test done");
      wr(4'h1, 32'h8);
      wr(4'h2, 32'he);
      for (md = 0; md < 8; md = md + 1) begin
         for (j = 0; j < 5; j = j + 1) begin
            t = j < 4 ? 7 + j % 2 + (j / 2) * 7 : 4 + {$random(seed)} % 17;
            fl = $random(seed);
            ien = $random(seed);
            e = hit(md, t);
            t0 = trig_n;
            u_src.put(fl, 3);
            wr(4'h7, {28'h0, ~fl});
            wr(4'h4, {31'h0, ien});
            wr(4'h0, {26'h0, fl[3:2], md[2:0], 1'b1});
            u_src.put(~fl, 2);
            u_src.put(fl, md > 3 ? t - 2 : t);
            u_src.put(~fl, 4);
            chk(trig_n - t0, e, "trig");
            rd(4'h3, e);
            chk(irq_o, e & ien, "irq");
            rd(4'h6, t);
            wr(4'h5, 32'h3);
            wr(4'h0, 32'h0);
         end
         $display("mode %0d test done", md);
      end
      repeat (2) @(posedge clk_i);
      chk(exq.size(), 0, "queue");
      wrap_up;
   end
endmodule
